//--- rtl/asrx_receiver.sv
// framed asynchronous serial receiver with wishbone register access
// Function
// - low 13 mode bits set baud
// - bit time is field plus 20 microseconds
// - mode bit 13 enables parity, else 8N1
// - parity default gives seven data, even parity
// - build option selects odd parity
// - mode bit 14 inverts data and flow
// - flow pin driven enabled to permit sending
// - bad parity aborts via parity error exit
// - idle line for timeout milliseconds aborts reception
// - character length 4 to 9 (9 only with parity), default 8
// - parity takes one bit; 9 gives 8+parity
// - raw item stores character code unchanged
// - decimal skips leading non-digits, value capped 65535
// - timing assumes 4 MHz, rescaled by setting
// - hex parsing accepts upper case only
// - wait item holds off until sequence matched
// - data pin input, flow pin output at start
//
// Decided for this implementation: the address map and the Wishbone register port.
module asrx_receiver
    import asrx_pkg::*;
#(
    parameter bit ODD_PARITY_SELECT = 1'b0
) (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic SERIAL_IN_PIN,
    output logic FLOW_CTRL_PIN_O,
    output logic FLOW_CTRL_PIN_OE
);

    typedef enum logic [2:0] {ST_IDLE, ST_HUNT, ST_START, ST_BITS, ST_STOP} asrx_state_t;

    asrx_state_t state_q;
    logic [31:0] ctrl_q, tmo_q, qual_q;
    logic [7:0] ref_q;
    asrx_ctrl_t ctrl;
    logic ack_q;
    logic [31:0] dat_q;
    logic done_q, perr_q, tmo_flag_q;
    logic flow_q, flow_oe_q;
    logic s1_q, s2_q, s3_q, line_q;
    logic idle_seen_q;
    logic [13:0] tcnt_q;
    logic [3:0] bit_idx_q;
    logic [8:0] shreg_q;
    logic [15:0] tmo_cnt_q;
    logic [7:0] skip_q;
    logic [2:0] qual_idx_q;
    logic [15:0] val_q;
    logic seen_q;

    assign ctrl = asrx_ctrl_t'(ctrl_q);

    // register bus decode
    logic wb_req, wb_wr, busy;
    logic [7:0] adr;
    logic start_p, abort_p;
    assign wb_req = WB_CYC_I & WB_STB_I & ~ack_q;
    assign wb_wr = wb_req & WB_WE_I;
    assign adr = {WB_ADR_I[7:2], 2'b00};
    assign busy = state_q != ST_IDLE;
    assign start_p = wb_wr & (adr == OFF_CMD) & WB_SEL_I[0] & WB_DAT_I[CMD_START_BIT] & ~busy;
    assign abort_p = wb_wr & (adr == OFF_CMD) & WB_SEL_I[0] & WB_DAT_I[CMD_ABORT_BIT] & busy;

    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    // configuration is frozen during a reception so timing cannot shift mid-frame
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_q <= CTRL_RESET;
            tmo_q <= TMO_RESET;
            qual_q <= QUAL_RESET;
            ref_q <= REF_MHZ_RESET;
        end else if (wb_wr && !busy) begin
            if (adr == OFF_CTRL) ctrl_q <= lane_merge(ctrl_q, WB_DAT_I, WB_SEL_I);
            if (adr == OFF_TMO) tmo_q <= lane_merge(tmo_q, WB_DAT_I, WB_SEL_I);
            if (adr == OFF_QUAL) qual_q <= lane_merge(qual_q, WB_DAT_I, WB_SEL_I);
            if (adr == OFF_REF && WB_SEL_I[0]) ref_q <= WB_DAT_I[7:0];
        end
    end

    asrx_status_t stat;
    always_comb begin
        stat = '0;
        stat.busy = busy;
        stat.done = done_q;
        stat.parity_err = perr_q;
        stat.timeout = tmo_flag_q;
        stat.qualified = qual_idx_q == ctrl.qual_len;
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= wb_req;
            if (wb_req && !WB_WE_I) begin
                case (adr)
                    OFF_CTRL: dat_q <= ctrl_q;
                    OFF_TMO: dat_q <= tmo_q;
                    OFF_QUAL: dat_q <= qual_q;
                    OFF_REF: dat_q <= {24'h000000, ref_q};
                    OFF_STAT: dat_q <= 32'(stat);
                    OFF_DATA: dat_q <= {16'h0000, val_q};
                    default: dat_q <= '0;
                endcase
            end
        end
    end
    assign WB_ACK_O = ack_q;
    assign WB_DAT_O = dat_q;

    // pin synchroniser: a change counts once the second and third stages agree
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            line_q <= 1'b1;
        end else begin
            s1_q <= SERIAL_IN_PIN;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) line_q <= s3_q;
        end
    end

    logic inv, par_en, rx_bit;
    assign inv = ctrl.mode[MODE_INV_BIT];
    assign par_en = ctrl.mode[MODE_PAR_BIT];
    assign rx_bit = line_q ^ inv;

    // microsecond and millisecond ticks
    logic [15:0] cyc_per_us;
    logic us_tick, ms_tick;
    logic [13:0] bit_us, target;
    logic sample_now;
    assign cyc_per_us = 16'((32'(ref_q) * CLK_MHZ) / REF_MHZ_DEFAULT);
    assign bit_us = 14'(ctrl.mode[MODE_BAUD_W-1:0]) + BIT_US_ADD;
    assign target = (state_q == ST_START) ? (bit_us >> 1) : bit_us;
    assign sample_now = us_tick & ((15'(tcnt_q) + 15'h0001) >= {1'b0, target});

    asrx_divider #(.W(16)) u_us_div (
        .clock(CLOCK),
        .rstn(RSTN),
        .clr(~busy),
        .en(1'b1),
        .period(cyc_per_us),
        .tick_q(us_tick)
    );

    asrx_divider #(.W(16)) u_ms_div (
        .clock(CLOCK),
        .rstn(RSTN),
        .clr((state_q != ST_HUNT) | ~rx_bit),
        .en(us_tick),
        .period(US_PER_MS),
        .tick_q(ms_tick)
    );

    // character decode
    logic [3:0] nb, dw;
    logic [7:0] ch;
    logic par_x, par_fail, is_dig;
    logic [3:0] dig;
    logic [19:0] dec_sum;
    logic [15:0] acc_next;
    always_comb begin
        if (ctrl.char_len == 4'h0) nb = CHAR_LEN_DEFAULT;
        else if (ctrl.char_len < CHAR_LEN_MIN) nb = CHAR_LEN_MIN;
        else if (ctrl.char_len > CHAR_LEN_MAX) nb = CHAR_LEN_MAX;
        else nb = ctrl.char_len;
        if (!par_en && nb == CHAR_LEN_MAX) nb = CHAR_LEN_DEFAULT;
        dw = par_en ? 4'(nb - 4'h1) : nb;
        ch = '0;
        par_x = ODD_PARITY_SELECT;
        for (int i = 0; i < 9; i++) begin
            if (i < 32'(nb)) par_x = par_x ^ shreg_q[i];
            if (i < 8 && i < 32'(dw)) ch[i] = shreg_q[i];
        end
        par_fail = par_en & par_x;
        is_dig = 1'b0;
        dig = 4'h0;
        case (ctrl.parse)
            ASRX_PARSE_DEC: begin
                is_dig = ch >= 8'h30 && ch <= 8'h39;
                dig = ch[3:0];
            end
            ASRX_PARSE_BIN: begin
                is_dig = ch == 8'h30 || ch == 8'h31;
                dig = ch[3:0];
            end
            ASRX_PARSE_HEX: begin
                // lower-case letters are terminators, not digits
                if (ch >= 8'h30 && ch <= 8'h39) begin
                    is_dig = 1'b1;
                    dig = ch[3:0];
                end else if (ch >= 8'h41 && ch <= 8'h46) begin
                    is_dig = 1'b1;
                    dig = 4'(ch - 8'h37);
                end
            end
            default: is_dig = 1'b0;
        endcase
        dec_sum = 20'(val_q) * DEC_BASE + 20'(dig);
        case (ctrl.parse)
            ASRX_PARSE_DEC: acc_next = dec_sum > DEC_MAX ? 16'hffff : dec_sum[15:0];
            ASRX_PARSE_BIN: acc_next = {val_q[14:0], dig[0]};
            ASRX_PARSE_HEX: acc_next = {val_q[11:0], dig};
            default: acc_next = 16'(ch);
        endcase
    end

    logic char_evt, perr_abort, qualified, item_done, tmo_hit;
    assign char_evt = (state_q == ST_STOP) & sample_now;
    assign perr_abort = char_evt & par_fail & ctrl.perr_exit_en;
    assign qualified = qual_idx_q == ctrl.qual_len;
    assign item_done = char_evt & ~perr_abort & (skip_q == 8'h00) & qualified &
                       ((ctrl.parse == ASRX_PARSE_RAW) | (~is_dig & seen_q));
    assign tmo_hit = ctrl.timeout_en & (state_q == ST_HUNT) & ms_tick &
                     ((17'(tmo_cnt_q) + 17'h00001) >= 17'(tmo_q[TMO_MS_LSB +: 16]));

    // frame state machine
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            state_q <= ST_IDLE;
            tcnt_q <= '0;
            bit_idx_q <= '0;
            shreg_q <= '0;
            idle_seen_q <= 1'b0;
        end else if (abort_p || tmo_hit || perr_abort || item_done) begin
            state_q <= ST_IDLE;
        end else begin
            if (us_tick) tcnt_q <= sample_now ? 14'h0000 : 14'(tcnt_q + 1'b1);
            case (state_q)
                ST_IDLE: begin
                    idle_seen_q <= 1'b0;
                    if (start_p) state_q <= ST_HUNT;
                end
                ST_HUNT: begin
                    tcnt_q <= '0;
                    if (rx_bit) idle_seen_q <= 1'b1;
                    else if (idle_seen_q) state_q <= ST_START;
                end
                ST_START: if (sample_now) begin
                    bit_idx_q <= '0;
                    state_q <= rx_bit ? ST_HUNT : ST_BITS; // glitch rejected
                    idle_seen_q <= rx_bit;
                end
                ST_BITS: if (sample_now) begin
                    shreg_q[bit_idx_q] <= rx_bit;
                    bit_idx_q <= 4'(bit_idx_q + 1'b1);
                    if (bit_idx_q == 4'(nb - 4'h1)) state_q <= ST_STOP;
                end
                ST_STOP: if (sample_now) begin
                    // a low stop bit leaves the hunt waiting for idle first
                    idle_seen_q <= rx_bit;
                    state_q <= ST_HUNT;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // idle time counted in whole milliseconds
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            tmo_cnt_q <= '0;
        end else if (state_q != ST_HUNT || !rx_bit) begin
            tmo_cnt_q <= '0;
        end else if (ms_tick) begin
            tmo_cnt_q <= 16'(tmo_cnt_q + 1'b1);
        end
    end

    // item handling: skip, qualifier wait, then store or parse
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            skip_q <= '0;
            qual_idx_q <= '0;
            val_q <= '0;
            seen_q <= 1'b0;
        end else if (start_p) begin
            skip_q <= tmo_q[TMO_SKIP_LSB +: 8];
            qual_idx_q <= '0;
            val_q <= '0;
            seen_q <= 1'b0;
        end else if (char_evt && !perr_abort) begin
            if (skip_q != 8'h00) begin
                skip_q <= 8'(skip_q - 1'b1);
            end else if (!qualified) begin
                // a mismatch restarts the sequence at its first character
                qual_idx_q <= (ch == qual_q[8*qual_idx_q[1:0] +: 8]) ?
                              3'(qual_idx_q + 1'b1) : 3'h0;
            end else if (ctrl.parse == ASRX_PARSE_RAW) begin
                val_q <= {8'h00, ch};
            end else if (is_dig) begin
                val_q <= acc_next;
                seen_q <= 1'b1;
            end
        end
    end

    // status flags: an exit arriving with a clear still sets the flag
    logic clr_wr;
    assign clr_wr = wb_wr & (adr == OFF_STAT) & WB_SEL_I[0];
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            done_q <= 1'b0;
            perr_q <= 1'b0;
            tmo_flag_q <= 1'b0;
        end else if (start_p) begin
            done_q <= 1'b0;
            perr_q <= 1'b0;
            tmo_flag_q <= 1'b0;
        end else begin
            done_q <= item_done | (done_q & ~(clr_wr & WB_DAT_I[1]));
            perr_q <= perr_abort | (perr_q & ~(clr_wr & WB_DAT_I[2]));
            tmo_flag_q <= tmo_hit | (tmo_flag_q & ~(clr_wr & WB_DAT_I[3]));
        end
    end

    // flow control: enabled only while waiting for a character
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            flow_q <= 1'b0;
            flow_oe_q <= 1'b0;
        end else begin
            if (start_p) flow_oe_q <= ctrl.flow_en;
            flow_q <= (state_q == ST_HUNT) ? ~inv : inv;
        end
    end
    assign FLOW_CTRL_PIN_O = flow_q;
    assign FLOW_CTRL_PIN_OE = flow_oe_q;

endmodule

//--- rtl/asrx_pkg.sv
// constants, register map and carrier types of the asynchronous serial receiver
package asrx_pkg;

    // system clock and microsecond timing
    localparam int CLK_MHZ = 250;
    localparam int REF_MHZ_DEFAULT = 4;
    localparam logic [7:0] REF_MHZ_RESET = 8'h04;
    localparam int BIT_US_ADD_US = 20;
    localparam logic [13:0] BIT_US_ADD = 14'(BIT_US_ADD_US);
    localparam int MS_UNIT_US = 1000;
    localparam logic [15:0] US_PER_MS = 16'(MS_UNIT_US);

    // mode word layout
    localparam int MODE_BAUD_W = 13;
    localparam int MODE_PAR_BIT = 13;
    localparam int MODE_INV_BIT = 14;

    // character length setting
    localparam logic [3:0] CHAR_LEN_DEFAULT = 4'h8;
    localparam logic [3:0] CHAR_LEN_MIN = 4'h4;
    localparam logic [3:0] CHAR_LEN_MAX = 4'h9;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_TMO = 8'h04;
    localparam logic [7:0] OFF_QUAL = 8'h08;
    localparam logic [7:0] OFF_REF = 8'h0c;
    localparam logic [7:0] OFF_CMD = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;
    localparam logic [7:0] OFF_DATA = 8'h18;

    // field positions outside the structs
    localparam int TMO_MS_LSB = 0;
    localparam int TMO_SKIP_LSB = 16;
    localparam int CMD_START_BIT = 0;
    localparam int CMD_ABORT_BIT = 1;

    // values after reset
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] TMO_RESET = 32'h0000_0000;
    localparam logic [31:0] QUAL_RESET = 32'h0000_0000;

    // numeric parsing limits
    localparam logic [19:0] DEC_BASE = 20'h0000a;
    localparam logic [19:0] DEC_MAX = 20'h0ffff;

    typedef enum logic [1:0] {
        ASRX_PARSE_RAW,
        ASRX_PARSE_DEC,
        ASRX_PARSE_BIN,
        ASRX_PARSE_HEX
    } asrx_parse_t;

    typedef struct packed {
        logic rsvd_hi;
        logic [2:0] qual_len;
        logic [3:0] char_len;
        logic [2:0] rsvd_mid;
        logic perr_exit_en;
        logic timeout_en;
        logic flow_en;
        asrx_parse_t parse;
        logic [15:0] mode;
    } asrx_ctrl_t;

    typedef struct packed {
        logic [26:0] rsvd;
        logic qualified;
        logic timeout;
        logic parity_err;
        logic done;
        logic busy;
    } asrx_status_t;

endpackage

//--- rtl/asrx_divider.sv
// enable-driven divider giving a one-cycle tick every period enables
module asrx_divider
    import asrx_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clr,
    input wire logic en,
    input wire logic [W-1:0] period,
    output logic tick_q
);

    logic [W-1:0] cnt_q;
    logic last;

    // a period of zero or one ticks on every enable
    assign last = ({1'b0, cnt_q} + 1'b1) >= {1'b0, period};

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (clr) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= en & last;
            if (en) begin
                cnt_q <= last ? '0 : W'(cnt_q + 1'b1);
            end
        end
    end

endmodule

//--- dv/asrx_receiver_asserts.sv
// concurrent checks on the receiver's bus and flow pins
module asrx_receiver_asserts
    import asrx_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic SERIAL_IN_PIN,
    input wire logic FLOW_CTRL_PIN_O,
    input wire logic FLOW_CTRL_PIN_OE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    logic take;
    logic start_req;
    logic inv_q;
    assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign start_req = take && WB_WE_I && WB_ADR_I == OFF_CMD && WB_DAT_I[CMD_START_BIT];
    // mirror of the invert bit, one edge behind the register
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            inv_q <= 1'b0;
        end else if (WB_ACK_O && WB_WE_I && WB_ADR_I == OFF_CTRL && WB_SEL_I[1]) begin
            inv_q <= WB_DAT_I[MODE_INV_BIT];
        end
    end
    sequence flow_enabled_soon;
        ##[0:4] FLOW_CTRL_PIN_O == !inv_q;
    endsequence
    a_ack_follows: assert property (take |=> WB_ACK_O)
        else $error("ack missing after request");
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (WB_ACK_O |-> $past(take))
        else $error("ack without request");
    a_req_quiet: assert property (!WB_STB_I ##1 !WB_STB_I |-> !WB_ACK_O)
        else $error("ack on idle bus");
    a_dat_hold: assert property (!WB_ACK_O |-> $stable(WB_DAT_O))
        else $error("read data moved outside ack");
    a_unmapped_zero: assert property (take && !WB_WE_I && WB_ADR_I >= 8'h1c |=> WB_DAT_O == 32'h0)
        else $error("unmapped read not zero");
    a_oe_on_start: assert property ($changed(FLOW_CTRL_PIN_OE) |->
        $past(start_req) || $past(start_req, 2))
        else $error("flow enable moved without start");
    a_flow_enables: assert property ($rose(FLOW_CTRL_PIN_OE) |-> flow_enabled_soon)
        else $error("flow not at enabled level");
endmodule

bind asrx_receiver asrx_receiver_asserts asrx_receiver_asserts_inst (.CLOCK(CLOCK), .RSTN(RSTN),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .SERIAL_IN_PIN(SERIAL_IN_PIN), .FLOW_CTRL_PIN_O(FLOW_CTRL_PIN_O),
    .FLOW_CTRL_PIN_OE(FLOW_CTRL_PIN_OE));

//--- dv/asrx_serial_tx.sv
// serial transmitter model facing the receiver's data pin
module asrx_serial_tx #(
    parameter int BIT_CYC = 1240
) (
    input wire logic clock,
    input wire logic inv,
    input wire logic flow_o,
    input wire logic flow_oe,
    output logic line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic bit_q = 1'b1;
    int bit_cyc = BIT_CYC;
    assign line = bit_q ^ inv;
    task automatic send(input logic [8:0] v, input int nb);
        int n;
        n = 0;
        // hold off while the receiver withholds permission
        while (flow_oe === 1'b1 && flow_o !== !inv && n < 10000) begin
            @(posedge clock);
            n++;
        end
        bit_q <= 1'b0;
        repeat (bit_cyc) @(posedge clock);
        for (int i = 0; i < nb; i++) begin
            bit_q <= v[i];
            repeat (bit_cyc) @(posedge clock);
        end
        bit_q <= 1'b1;
        repeat (bit_cyc) @(posedge clock);
    endtask
endmodule

//--- dv/test_asrx_receiver.sv
// self-checking bench for the asynchronous serial receiver
module test_asrx_receiver
    import asrx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hf;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic sin;
    logic fo;
    logic foe;
    logic inv = 1'b0;
    int mismatches = 0;
    int checks = 0;

    asrx_receiver asrx_receiver_inst (.CLOCK(clock), .RSTN(rstn), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .SERIAL_IN_PIN(sin), .FLOW_CTRL_PIN_O(fo),
        .FLOW_CTRL_PIN_OE(foe));
    // mode field 0 gives 20 us bits; with a 1 MHz reference a us is 62 cycles
    asrx_serial_tx #(.BIT_CYC(1240)) asrx_serial_tx_inst (.clock(clock), .inv(inv),
        .flow_o(fo), .flow_oe(foe), .line(sin));

    initial begin
        forever #2 clock = ~clock;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 100);
        chk("bus ack", 32'h1, {31'h0, ack});
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        wb(1'b1, a, d, x);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        logic [31:0] x;
        wb(1'b0, a, 32'h0, x);
        chk(n, e, x);
    endtask

    // polls status until busy drops; bounded so a stuck receiver cannot hang
    task automatic wait_idle();
        logic [31:0] s;
        int n;
        n = 0;
        s = 32'h1;
        while (s[0] !== 1'b0 && n < 40000) begin
            wb(1'b0, OFF_STAT, 32'h0, s);
            n++;
        end
        chk("idle wait", 32'h0, {31'h0, s[0]});
    endtask

    task automatic s_regs();
        chk("oe reset", 32'h0, {31'h0, foe});
        rd(OFF_CTRL, CTRL_RESET, "ctrl");
        rd(OFF_TMO, TMO_RESET, "tmo");
        rd(OFF_QUAL, QUAL_RESET, "qual");
        rd(OFF_REF, {24'h0, REF_MHZ_RESET}, "ref");
        rd(OFF_STAT, 32'h10, "stat");
        wr(8'h1c, 32'hffff_ffff);
        rd(8'h1c, 32'h0, "unmapped");
        wr(OFF_REF, 32'h1);
        rd(OFF_REF, 32'h1, "ref set");
    endtask

    task automatic s_raw();
        inv <= 1'b0;
        wr(OFF_CTRL, 32'h0004_8000);
        wr(OFF_CMD, 32'h1);
        asrx_serial_tx_inst.send(9'h0a5, 8);
        wait_idle();
        chk("flow oe", 32'h1, {31'h0, foe});
        chk("flow off", 32'h0, {31'h0, fo});
        rd(OFF_STAT, 32'h12, "raw stat");
        rd(OFF_DATA, 32'ha5, "raw data");
    endtask

    task automatic s_parity();
        inv <= 1'b1;
        wr(OFF_CTRL, 32'h0000_6000);
        wr(OFF_CMD, 32'h1);
        asrx_serial_tx_inst.send(9'h0c3, 8);
        wait_idle();
        rd(OFF_STAT, 32'h12, "par stat");
        rd(OFF_DATA, 32'h43, "par data");
        chk("flow idle", 32'h1, {31'h0, fo});
    endtask

    task automatic s_perr();
        logic [31:0] x;
        inv <= 1'b0;
        wr(OFF_CTRL, 32'h0410_2000);
        wr(OFF_CMD, 32'h1);
        // three data bits 101 with a parity bit that breaks even parity
        asrx_serial_tx_inst.send(9'h00d, 4);
        wait_idle();
        wb(1'b0, OFF_STAT, 32'h0, x);
        chk("perr stat", 32'h4, x & 32'h5);
    endtask

    task automatic send_str(input string s);
        for (int i = 0; i < s.len(); i++) begin
            asrx_serial_tx_inst.send(9'(s[i]), 8);
        end
    endtask

    // a zero reference ticks every cycle; 20-cycle bits keep multi-character runs short
    task automatic s_parse();
        inv <= 1'b0;
        wr(OFF_REF, 32'h0);
        asrx_serial_tx_inst.bit_cyc = 20;
        wr(OFF_CTRL, 32'h0001_0000);
        wr(OFF_CMD, 32'h1);
        send_str("x42,");
        wait_idle();
        rd(OFF_DATA, 32'h2a, "dec data");
        wr(OFF_CMD, 32'h1);
        send_str("70000,");
        wait_idle();
        rd(OFF_DATA, 32'hffff, "dec cap");
        wr(OFF_CTRL, 32'h0003_0000);
        wr(OFF_CMD, 32'h1);
        send_str("1Fa");
        wait_idle();
        rd(OFF_DATA, 32'h1f, "hex data");
        wr(OFF_CTRL, 32'h0002_0000);
        wr(OFF_CMD, 32'h1);
        send_str("1012");
        wait_idle();
        rd(OFF_DATA, 32'h5, "bin data");
    endtask

    task automatic s_wide();
        wr(OFF_CTRL, 32'h0900_2000);
        wr(OFF_CMD, 32'h1);
        asrx_serial_tx_inst.send(9'h0a5, 9);
        wait_idle();
        rd(OFF_STAT, 32'h12, "wide stat");
        rd(OFF_DATA, 32'ha5, "wide data");
    endtask

    // one skipped char, then a broken and a whole "AB" before the stored char
    task automatic s_qual();
        wr(OFF_TMO, 32'h0001_0000);
        wr(OFF_QUAL, 32'h0000_4241);
        wr(OFF_CTRL, 32'h2000_0000);
        wr(OFF_CMD, 32'h1);
        send_str("BAAAB7");
        wait_idle();
        rd(OFF_STAT, 32'h12, "qual stat");
        rd(OFF_DATA, 32'h37, "qual data");
    endtask

    task automatic s_abort();
        wr(OFF_CTRL, 32'h0);
        wr(OFF_CMD, 32'h1);
        rd(OFF_STAT, 32'h11, "busy stat");
        wr(OFF_CMD, 32'h2);
        rd(OFF_STAT, 32'h10, "abort stat");
    endtask

    task automatic s_timeout();
        longint t0;
        wr(OFF_REF, 32'h1);
        wr(OFF_TMO, 32'h1);
        wr(OFF_CTRL, 32'h0008_0000);
        t0 = $time;
        wr(OFF_CMD, 32'h1);
        wait_idle();
        rd(OFF_STAT, 32'h18, "tmo stat");
        t0 = $time - t0;
        chk("tmo span", 32'h1, {31'h0, t0 > 240000 && t0 < 270000});
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #450000;
        mismatches++;
        final_report();
    end

    initial begin
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        s_regs();
        s_raw();
        s_parity();
        s_parse();
        s_perr();
        s_wide();
        s_qual();
        s_abort();
        s_timeout();
        final_report();
    end
endmodule
